//--- perf_event_defines.vh
// event codes and widths for the group b performance event qualifier
`ifndef PERF_EVENT_DEFINES_VH
`define PERF_EVENT_DEFINES_VH

`define EVT_SEL_W 6
`define EVT_INC_W 3
`define PIPES 2

`define EVT_SEG_LOAD 6'h0F
`define EVT_BRANCH 6'h12
`define EVT_BTB_HIT 6'h13
`define EVT_TAKEN_OR_HIT 6'h14
`define EVT_PIPE_FLUSH 6'h15
`define EVT_INSTR 6'h16
`define EVT_INSTR_PIPE1 6'h17
`define EVT_BUS_BUSY 6'h18
`define EVT_WBUF_STALL 6'h19

`define INC_RESET 3'h0

`endif

//--- pipe_event_qualifier.v
// per-pipe qualification of instruction events, all gated by retire except segment loads
`timescale 1ns/1ps
`include "perf_event_defines.vh"

module pipe_event_qualifier (
  input wire core_clk,
  input wire rst,
  input wire retire,
  input wire branch_instr,
  input wire branch_taken,
  input wire serializing_instr,
  input wire segment_verify,
  input wire desc_load_branch,
  input wire btb_hit,
  input wire rep_string,
  input wire halt_instruction,
  input wire seg_write,
  input wire priv_change,
  output wire [1:0] segment_load_event,
  output wire branch_event,
  output wire branch_target_hit_event,
  output wire taken_or_target_hit_event,
  output wire instr_event
);

  // set while a repeat string keeps retiring iterations
  reg rep_active;
  // set while the same halt stays at retirement
  reg halt_active;
  wire taken_class;

  // only the first retirement of a repeat string counts
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rep_active <= 1'b0;
      halt_active <= 1'b0;
    end else begin
      rep_active <= retire & rep_string; // RL11
      halt_active <= retire & halt_instruction; // RL12
    end
  end

  // instructions that behave as taken branches
  assign taken_class = branch_taken | serializing_instr | segment_verify | desc_load_branch; // RL4

  // a privilege change on a far transfer counts twice
  assign segment_load_event = !seg_write ? 2'h0 : (priv_change ? 2'h2 : 2'h1); // RL1 RL2
  // retire gating keeps predicted but squashed work out
  assign branch_event = retire & (branch_instr | taken_class); // RL3 RL5
  assign branch_target_hit_event = retire & btb_hit; // RL6
  assign taken_or_target_hit_event = retire & (taken_class | btb_hit); // RL7
  assign instr_event = retire & ~(rep_string & rep_active) &
    ~(halt_instruction & halt_active); // RL10 RL11 RL12

endmodule

//--- perf_event_qualifier.v
// event qualifier for performance counter codes 0FH to 19H
//
// Contract
// RL1 - code 0FH counts every segment register write, including the descriptor table and task regs.
// RL2 - a far transfer or task switch that changes privilege adds two to the segment load count.
// RL3 - code 12H counts every executed branch, taken or not, of every branch kind.
// RL4 - serializing, verify, some descriptor loads, interrupts and trapping exceptions count as taken.
// RL5 - branches are counted as executed, never as predicted.
// RL6 - code 13H counts target buffer hits only for instructions that execute.
// RL7 - code 14H counts the OR of a taken branch and a target buffer hit.
// RL8 - code 15H counts flushes from buffer misses, mispredicts, exceptions, interrupts, descriptor loads.
// RL9 - serializing instructions and software interrupts do not count as pipeline flushes.
// RL10 - code 16H counts executed instructions, up to two per clock, plus interrupt and fault entries.
// RL11 - a repeat string instruction counts once however many iterations it runs.
// RL12 - a halt counts once however long the core stays halted.
// RL13 - code 17H counts as 16H but only instructions in the second pipe.
// RL14 - code 18H counts each clock of a bus cycle, including hold, address hold and backoff clocks.
// RL15 - code 19H counts clocks stalled on full write buffers, except stalls on I/O accesses.
// RL16 - each clock the increment is the number of qualifying occurrences in that clock.
`timescale 1ns/1ps
`include "perf_event_defines.vh"

module perf_event_qualifier (
  input wire core_clk,
  input wire rst,
  input wire [`EVT_SEL_W-1:0] event_select,
  input wire [`PIPES-1:0] retire,
  input wire [`PIPES-1:0] branch_instr,
  input wire [`PIPES-1:0] branch_taken,
  input wire [`PIPES-1:0] serializing_instr,
  input wire [`PIPES-1:0] segment_verify,
  input wire [`PIPES-1:0] desc_load_branch,
  input wire [`PIPES-1:0] btb_hit,
  input wire [`PIPES-1:0] rep_string,
  input wire [`PIPES-1:0] halt_instruction,
  input wire [`PIPES-1:0] seg_write,
  input wire [`PIPES-1:0] priv_change,
  input wire hw_interrupt,
  input wire cache_flush_request,
  input wire trap_fault_entry,
  input wire sw_int_exception_entry,
  input wire flush_btb_miss_taken,
  input wire flush_mispredict,
  input wire flush_exception,
  input wire flush_interrupt,
  input wire flush_desc_load,
  input wire bus_cycle_active,
  input wire hold_acknowledge,
  input wire address_hold_input,
  input wire bus_backoff_input,
  input wire wbuf_full_stall,
  input wire stall_io_access,
  output reg [`EVT_INC_W-1:0] event_increment,
  output reg event_code_valid
);

  // add two one-bit occurrences into an increment
  function [`EVT_INC_W-1:0] add2;
    input a;
    input b;
    begin
      add2 = {2'h0, a} + {2'h0, b};
    end
  endfunction

  // true when a code belongs to this group and is not reserved
  function in_group;
    input [`EVT_SEL_W-1:0] code;
    begin
      in_group = (code == `EVT_SEG_LOAD) ||
        ((code >= `EVT_BRANCH) && (code <= `EVT_WBUF_STALL));
    end
  endfunction

  wire [1:0] seg_ev [0:`PIPES-1];
  wire [`PIPES-1:0] branch_ev;
  wire [`PIPES-1:0] hit_ev;
  wire [`PIPES-1:0] taken_hit_ev;
  wire [`PIPES-1:0] instr_ev;

  // one qualifier per pipe
  genvar p;
  generate
    for (p = 0; p < `PIPES; p = p + 1) begin : g_pipe
      pipe_event_qualifier u_qual (
        .core_clk(core_clk),
        .rst(rst),
        .retire(retire[p]),
        .branch_instr(branch_instr[p]),
        .branch_taken(branch_taken[p]),
        .serializing_instr(serializing_instr[p]),
        .segment_verify(segment_verify[p]),
        .desc_load_branch(desc_load_branch[p]),
        .btb_hit(btb_hit[p]),
        .rep_string(rep_string[p]),
        .halt_instruction(halt_instruction[p]),
        .seg_write(seg_write[p]),
        .priv_change(priv_change[p]),
        .segment_load_event(seg_ev[p]),
        .branch_event(branch_ev[p]),
        .branch_target_hit_event(hit_ev[p]),
        .taken_or_target_hit_event(taken_hit_ev[p]),
        .instr_event(instr_ev[p])
      );
    end
  endgenerate

  // core-wide events not tied to a retiring slot, and the per-clock sums across pipes
  wire async_taken;
  wire entry_instr;
  wire flush_event;
  wire bus_busy_clock_event;
  wire wbuf_stall_clock_event;
  wire [`EVT_INC_W-1:0] segment_load_event;
  wire [`EVT_INC_W-1:0] branch_count;
  wire [`EVT_INC_W-1:0] instr_count;

  // hardware interrupts, flush requests and trapping exceptions
  assign async_taken = hw_interrupt | cache_flush_request | trap_fault_entry; // RL4
  assign entry_instr = hw_interrupt | trap_fault_entry | sw_int_exception_entry; // RL10

  // software interrupts and serializing flushes are not flush causes
  assign flush_event = flush_btb_miss_taken | flush_mispredict | flush_exception |
    flush_interrupt | flush_desc_load; // RL8 RL9

  // any clock the bus is owned, held or backed off
  assign bus_busy_clock_event = bus_cycle_active | hold_acknowledge |
    address_hold_input | bus_backoff_input; // RL14
  // io stalls excluded even when buffers are full
  assign wbuf_stall_clock_event = wbuf_full_stall & ~stall_io_access; // RL15

  // per-clock sums across pipes
  assign segment_load_event = {1'b0, seg_ev[0]} + {1'b0, seg_ev[1]}; // RL16
  assign branch_count = add2(branch_ev[0], branch_ev[1]) + {2'h0, async_taken}; // RL16
  assign instr_count = add2(instr_ev[0], instr_ev[1]) + {2'h0, entry_instr}; // RL10

  reg [`EVT_INC_W-1:0] next_increment;

  // select the increment for the chosen code
  always @* begin
    case (event_select)
      `EVT_SEG_LOAD: next_increment = segment_load_event; // RL1
      `EVT_BRANCH: next_increment = branch_count; // RL3
      `EVT_BTB_HIT: next_increment = add2(hit_ev[0], hit_ev[1]); // RL6
      `EVT_TAKEN_OR_HIT: next_increment = add2(taken_hit_ev[0], taken_hit_ev[1]); // RL7
      `EVT_PIPE_FLUSH: next_increment = {2'h0, flush_event}; // RL8
      `EVT_INSTR: next_increment = instr_count; // RL10
      `EVT_INSTR_PIPE1: next_increment = {2'h0, instr_ev[1]}; // RL13
      `EVT_BUS_BUSY: next_increment = {2'h0, bus_busy_clock_event}; // RL14
      `EVT_WBUF_STALL: next_increment = {2'h0, wbuf_stall_clock_event}; // RL15
      default: next_increment = `INC_RESET;
    endcase
  end

  // registered so the counter sees a clean one-cycle value
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      event_increment <= `INC_RESET;
      event_code_valid <= 1'b0;
    end else begin
      event_increment <= next_increment; // RL16
      event_code_valid <= in_group(event_select);
    end
  end

endmodule

//--- perf_event_props.sv
// concurrent checks on the event qualifier ports
`timescale 1ns/1ps
`include "perf_event_defines.vh"
module perf_event_props (
  input logic core_clk,
  input logic rst,
  input logic [5:0] event_select,
  input logic [1:0] retire,
  input logic [1:0] seg_write,
  input logic [1:0] priv_change,
  input logic flush_mispredict,
  input logic bus_cycle_active,
  input logic hold_acknowledge,
  input logic address_hold_input,
  input logic bus_backoff_input,
  input logic wbuf_full_stall,
  input logic stall_io_access,
  input logic [2:0] event_increment,
  input logic event_code_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_bus_busy_count: assert property (
    event_select == `EVT_BUS_BUSY |=> event_increment == {2'h0, $past(bus_cycle_active |
    hold_acknowledge | address_hold_input | bus_backoff_input)}) else $error("bus count wrong");
  a_wbuf_stall_count: assert property (
    event_select == `EVT_WBUF_STALL && wbuf_full_stall && !stall_io_access
    |=> event_increment == 3'h1) else $error("stall count wrong");
  a_io_stall_skipped: assert property (
    event_select == `EVT_WBUF_STALL && stall_io_access |=> event_increment == 3'h0)
    else $error("io stall counted");
  a_flush_one: assert property (
    event_select == `EVT_PIPE_FLUSH && flush_mispredict |=> event_increment == 3'h1)
    else $error("flush count wrong");
  a_code_valid: assert property (
    1'b1 |=> event_code_valid == $past(event_select == `EVT_SEG_LOAD ||
    (event_select >= `EVT_BRANCH && event_select <= `EVT_WBUF_STALL))) else $error("valid wrong");
  a_reserved_zero: assert property (
    event_select == 6'h10 || event_select == 6'h11 |=> event_increment == 3'h0)
    else $error("reserved code counted");
  a_seg_priv_two: assert property (
    event_select == `EVT_SEG_LOAD && retire == 2'h1 && seg_write == 2'h1 && priv_change == 2'h1
    |=> event_increment == 3'h2) else $error("privilege load not doubled");
  a_pipe1_only: assert property (
    event_select == `EVT_INSTR_PIPE1 && retire == 2'h1 |=> event_increment == 3'h0)
    else $error("first pipe counted as second");
endmodule

bind perf_event_qualifier perf_event_props perf_event_props_i (.core_clk(core_clk), .rst(rst),
  .event_select(event_select), .retire(retire), .seg_write(seg_write),
  .priv_change(priv_change), .flush_mispredict(flush_mispredict),
  .bus_cycle_active(bus_cycle_active), .hold_acknowledge(hold_acknowledge),
  .address_hold_input(address_hold_input), .bus_backoff_input(bus_backoff_input),
  .wbuf_full_stall(wbuf_full_stall), .stall_io_access(stall_io_access),
  .event_increment(event_increment), .event_code_valid(event_code_valid));

//--- core_side.sv
// core pipeline and bus unit model: holds event levels between steps
`timescale 1ns/1ps
module core_side (
  output reg [36:0] s
);
  initial s = 37'h0;
  // levels only change when stepped, just after a clock edge
  task put(input [36:0] v);
    s = v;
  endtask
endmodule

//--- test_perf_event_qualifier.sv
// scenario bench for the event qualifier
`timescale 1ns/1ps
`include "perf_event_defines.vh"
module test_perf_event_qualifier;
  localparam RT = 0, BR = 2, TK = 4, SE = 6, VF = 8, DL = 10, BH = 12, RP = 14, HT = 16;
  localparam SW = 18, PV = 20, HW = 22, TF = 24, FL = 26, BS = 31, WB = 35, IO = 36;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg [5:0] event_select = 6'h00;
  wire [36:0] s;
  wire [2:0] event_increment;
  wire event_code_valid;
  integer fails = 0, tests_run = 0, cyc = 0, i;
  core_side core_side_i (.s(s));
  perf_event_qualifier perf_event_qualifier_i (.core_clk(core_clk), .rst(rst),
    .event_select(event_select), .retire(s[1:0]), .branch_instr(s[3:2]), .branch_taken(s[5:4]),
    .serializing_instr(s[7:6]), .segment_verify(s[9:8]), .desc_load_branch(s[11:10]),
    .btb_hit(s[13:12]), .rep_string(s[15:14]), .halt_instruction(s[17:16]),
    .seg_write(s[19:18]), .priv_change(s[21:20]), .hw_interrupt(s[22]),
    .cache_flush_request(s[23]), .trap_fault_entry(s[24]), .sw_int_exception_entry(s[25]),
    .flush_btb_miss_taken(s[26]), .flush_mispredict(s[27]), .flush_exception(s[28]),
    .flush_interrupt(s[29]), .flush_desc_load(s[30]), .bus_cycle_active(s[31]),
    .hold_acknowledge(s[32]), .address_hold_input(s[33]), .bus_backoff_input(s[34]),
    .wbuf_full_stall(s[35]), .stall_io_access(s[36]), .event_increment(event_increment),
    .event_code_valid(event_code_valid));
  initial forever #10 core_clk = ~core_clk;
  function [36:0] b(input integer k, input [1:0] x);
    b = {35'h0, x} << k;
  endfunction
  task chk(input string nm, input [2:0] seen, input [2:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask
  // one cycle: levels held for one edge, registered answer read after it lands
  task go(input [5:0] sel, input [36:0] v, input [2:0] e);
    event_select = sel;
    core_side_i.put(v);
    @(posedge core_clk);
    #1;
    chk("event_increment", event_increment, e);
  endtask
  task t_seg;
    go(`EVT_SEG_LOAD, b(RT, 3) | b(SW, 3) | b(PV, 1), 3'h3);
    go(`EVT_SEG_LOAD, b(RT, 3) | b(SW, 3) | b(PV, 3), 3'h4);
    go(`EVT_SEG_LOAD, b(RT, 1) | b(SW, 1), 3'h1);
    go(`EVT_SEG_LOAD, b(RT, 1) | b(SW, 1) | b(PV, 1), 3'h2);
  endtask
  task t_branch;
    go(`EVT_BRANCH, b(RT, 3) | b(BR, 3), 3'h2);
    go(`EVT_BRANCH, b(RT, 1) | b(SE, 1) | (37'h1 << (HW + 1)), 3'h2);
    go(`EVT_BRANCH, b(RT, 2) | b(VF, 2) | (37'h1 << TF), 3'h2);
    go(`EVT_BRANCH, b(RT, 1) | b(DL, 1), 3'h1);
    go(`EVT_BRANCH, b(BR, 3) | b(BH, 3), 3'h0);
  endtask
  task t_hit;
    go(`EVT_BTB_HIT, b(RT, 1) | b(BH, 1), 3'h1);
    go(`EVT_BTB_HIT, b(RT, 2) | b(BH, 1), 3'h0);
    go(`EVT_TAKEN_OR_HIT, b(RT, 3) | b(BR, 1) | b(TK, 1) | b(BH, 2), 3'h2);
    go(`EVT_TAKEN_OR_HIT, b(RT, 1) | b(BR, 1), 3'h0);
  endtask
  task t_flush;
    for (i = 0; i < 5; i = i + 1) go(`EVT_PIPE_FLUSH, 37'h1 << (FL + i), 3'h1);
    go(`EVT_PIPE_FLUSH, b(FL + 1, 3), 3'h1);
    go(`EVT_PIPE_FLUSH, b(RT, 1) | b(SE, 1) | (37'h1 << (TF + 1)), 3'h0);
  endtask
  task t_instr;
    go(`EVT_INSTR, b(RT, 3) | (37'h1 << HW), 3'h3);
    go(`EVT_INSTR, b(RT, 1) | (37'h1 << (TF + 1)), 3'h2);
    for (i = 0; i < 3; i = i + 1) go(`EVT_INSTR, b(RT, 1) | b(RP, 1), {2'h0, i == 0});
    go(`EVT_INSTR, 37'h0, 3'h0);
    for (i = 0; i < 3; i = i + 1) go(`EVT_INSTR, b(RT, 2) | b(HT, 2), {2'h0, i == 0});
    go(`EVT_INSTR_PIPE1, b(RT, 2) | (37'h1 << HW), 3'h1);
    go(`EVT_INSTR_PIPE1, b(RT, 1), 3'h0);
  endtask
  task t_bus;
    for (i = 0; i < 4; i = i + 1) go(`EVT_BUS_BUSY, 37'h1 << (BS + i), 3'h1);
    go(`EVT_BUS_BUSY, b(RT, 3), 3'h0);
    go(`EVT_WBUF_STALL, 37'h1 << WB, 3'h1);
    chk("event_code_valid", {2'h0, event_code_valid}, 3'h1);
    go(`EVT_WBUF_STALL, b(WB, 3), 3'h0);
    go(6'h10, b(RT, 3) | b(BR, 3), 3'h0);
    chk("event_code_valid", {2'h0, event_code_valid}, 3'h0);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard, far above the few dozen cycles the scenarios need
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 400) begin
      fails = fails + 1;
      stop_test;
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    #1 rst = 1'b0;
    t_seg;
    t_branch;
    t_hit;
    t_flush;
    t_instr;
    t_bus;
    stop_test;
  end
endmodule
